//--- hdl/rgtlc_core.v
// Receive gain, duplex mask and LO synthesizer word control core
// Functional notes
// - Register mode: each channel attenuation follows its 6-bit register code, 0 to 42.
// - Up/down: strobe fall with direction low lowers attenuation by one step.
// - Up/down: strobe with direction high raises attenuation by one step.
// - Opposite direction at strobe rise and fall resets code to 111111.
// - Step field bits 4:3: 1, 2, 4 or 8 dB per strobe.
// - Step size resets to 1 dB.
// - Up/down counter saturates at both ends, never wraps.
// - Each channel has a duplex pin: low active, high disabled.
// - A set mask bit switches its block off during duplex off time.
// - Per-channel LO, IF and VGA masks act when either duplex pin high.
// - First LO stage mask bit 0 acts only when both pins high.
// - Synthesizer mask bit 7 acts only when both pins high.
// - Mask resets: bits 0 and 7 zero, others one.
// - LO divide select 10000/01000/00100/00010 picks divide 16/8/4/2.
// - Software writes integer low byte last; that write starts VCO autotune.
// - Feedback value is integer plus fraction terms over 16,777,216.
// - Integer word 16 bits over two bytes; software keeps its range.
// - Primary numerator is 24 bits, most significant byte highest address.
// - Auxiliary numerator and modulus 14 bits; software keeps modulus 2..16,383.
// - Comparison rate scales by doubler bit 3, halver bit 0, count 6:0.
// - Gain mode field: 01 register control, 11 up/down control.
// - Each channel attenuation readable from its readback register.
`timescale 1ns/1ns
`include "rgtlc_defs.vh"
module rgtlc_core #(
  parameter AUTOTUNE_CYCLES = (`RGTLC_AUTOTUNE_US * 1000) / `RGTLC_CLK_NS
) (
  input wire CORE_CLK,
  input wire RESETN,
  input wire REG_WR,
  input wire REG_RD,
  input wire [15:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  output reg REG_RVALID,
  input wire CHAN_A_GAIN_STEP_STROBE_PIN,
  input wire CHAN_A_GAIN_STEP_DIRECTION_PIN,
  input wire CHAN_B_GAIN_STEP_STROBE_PIN,
  input wire CHAN_B_GAIN_STEP_DIRECTION_PIN,
  input wire CHAN_A_DUPLEX_OFF_PIN,
  input wire CHAN_B_DUPLEX_OFF_PIN,
  output reg [5:0] CHAN_A_ATTEN_CODE,
  output reg [5:0] CHAN_B_ATTEN_CODE,
  output reg FIRST_LO_STAGE_OFF,
  output reg CHAN_A_LATER_LO_OFF,
  output reg CHAN_B_LATER_LO_OFF,
  output reg CHAN_A_IFAMP_OFF,
  output reg CHAN_B_IFAMP_OFF,
  output reg CHAN_A_VGA_OFF,
  output reg CHAN_B_VGA_OFF,
  output reg SYNTH_OFF,
  output reg [4:0] LO_DIVIDE_RATIO,
  output reg LO_DIVIDE_VALID,
  output reg [15:0] WHOLE_DIVIDE,
  output reg [23:0] PRIMARY_NUMERATOR,
  output reg [13:0] AUX_NUMERATOR,
  output reg [13:0] AUX_DENOMINATOR,
  output reg [6:0] REFERENCE_COUNT,
  output reg REFERENCE_DOUBLE,
  output reg REFERENCE_HALVE,
  output reg AUTOTUNE_START,
  output reg AUTOTUNE_BUSY
);
  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  reg [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];
  always @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [7:0] mask_q;
  reg [7:0] gcfg_q;
  reg [7:0] att_a_q;
  reg [7:0] att_b_q;
  reg [1:0] gain_rst_q;
  reg [7:0] int_lo_q;
  reg [7:0] int_hi_q;
  reg [7:0] num0_q;
  reg [7:0] num1_q;
  reg [7:0] num2_q;
  reg [7:0] den_lo_q;
  reg [7:0] den_hi_q;
  reg [7:0] refcnt_q;
  reg [7:0] refscl_q;
  reg [7:0] aux_lo_q;
  reg [7:0] aux_hi_q;
  reg [7:0] loctl_q;
  wire [5:0] code_a;
  wire [5:0] code_b;

  // Address match helper, used by the write decode only; reads use a case
  function hit;
    input [15:0] addr;
    input [15:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  wire reg_mode = (gcfg_q[2:0] == `RGTLC_MODE_REG);
  wire updn_mode = (gcfg_q[2:0] == `RGTLC_MODE_UPDN);
  wire int_lo_wr = REG_WR && hit(REG_ADDR, `RGTLC_OFF_INT_LO);

  ////////////////////////////////////////////////////////////////////////
  // Register writes; the gain reset bits are self-clearing pulses
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q <= `RGTLC_MASK_RST;
      gcfg_q <= `RGTLC_GCFG_RST;
      att_a_q <= `RGTLC_ATT_RST;
      att_b_q <= `RGTLC_ATT_RST;
      gain_rst_q <= 2'h0;
      int_lo_q <= `RGTLC_INT_RST;
      int_hi_q <= `RGTLC_INT_RST;
      num0_q <= 8'h00;
      num1_q <= 8'h00;
      num2_q <= 8'h00;
      den_lo_q <= 8'h02;
      den_hi_q <= 8'h00;
      refcnt_q <= `RGTLC_REFCNT_RST;
      refscl_q <= 8'h00;
      aux_lo_q <= 8'h00;
      aux_hi_q <= 8'h00;
      loctl_q <= `RGTLC_LOCTL_RST;
    end
    else
    begin
      gain_rst_q <= 2'h0;
      if (REG_WR)
      begin
        if (hit(REG_ADDR, `RGTLC_OFF_MASK))
          mask_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_GCFG))
          gcfg_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_ATT_A))
          att_a_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_ATT_B))
          att_b_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_GAIN_RST))
          gain_rst_q <= {REG_WDATA[`RGTLC_BIT_RST_A], REG_WDATA[`RGTLC_BIT_RST_B]};
        if (int_lo_wr)
          int_lo_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_INT_HI))
          int_hi_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_NUM0))
          num0_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_NUM1))
          num1_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_NUM2))
          num2_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_DEN_LO))
          den_lo_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_DEN_HI))
          den_hi_q <= {2'h0, REG_WDATA[5:0]};
        if (hit(REG_ADDR, `RGTLC_OFF_REFCNT))
          refcnt_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_REFSCL))
          refscl_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_AUX_LO))
          aux_lo_q <= REG_WDATA;
        if (hit(REG_ADDR, `RGTLC_OFF_AUX_HI))
          aux_hi_q <= {2'h0, REG_WDATA[5:0]};
        if (hit(REG_ADDR, `RGTLC_OFF_LOCTL))
          loctl_q <= REG_WDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two gain link channels; codes written in up/down mode are held in the
  // register and reach the counter only once register mode is selected
  rgtlc_gain_link u_chan_a (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .strobe_pin(CHAN_A_GAIN_STEP_STROBE_PIN),
    .dir_pin(CHAN_A_GAIN_STEP_DIRECTION_PIN),
    .updn_mode(updn_mode),
    .reg_mode(reg_mode),
    .reg_code(att_a_q[5:0]),
    .step_sel(gcfg_q[4:3]),
    .block_reset(gain_rst_q[1]),
    .atten_code_q(code_a)
  );
  rgtlc_gain_link u_chan_b (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .strobe_pin(CHAN_B_GAIN_STEP_STROBE_PIN),
    .dir_pin(CHAN_B_GAIN_STEP_DIRECTION_PIN),
    .updn_mode(updn_mode),
    .reg_mode(reg_mode),
    .reg_code(att_b_q[5:0]),
    .step_sel(gcfg_q[4:3]),
    .block_reset(gain_rst_q[0]),
    .atten_code_q(code_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register read, one cycle after the strobe; unmapped reads return zero
  reg [7:0] rd_mux;
  always @*
  begin
    rd_mux = 8'h00;
    case (REG_ADDR)
      `RGTLC_OFF_RDBK_A: rd_mux = {2'h0, code_a};
      `RGTLC_OFF_RDBK_B: rd_mux = {2'h0, code_b};
      `RGTLC_OFF_MASK: rd_mux = mask_q;
      `RGTLC_OFF_GCFG: rd_mux = gcfg_q;
      `RGTLC_OFF_ATT_A: rd_mux = att_a_q;
      `RGTLC_OFF_ATT_B: rd_mux = att_b_q;
      `RGTLC_OFF_INT_LO: rd_mux = int_lo_q;
      `RGTLC_OFF_INT_HI: rd_mux = int_hi_q;
      `RGTLC_OFF_NUM0: rd_mux = num0_q;
      `RGTLC_OFF_NUM1: rd_mux = num1_q;
      `RGTLC_OFF_NUM2: rd_mux = num2_q;
      `RGTLC_OFF_DEN_LO: rd_mux = den_lo_q;
      `RGTLC_OFF_DEN_HI: rd_mux = den_hi_q;
      `RGTLC_OFF_REFCNT: rd_mux = refcnt_q;
      `RGTLC_OFF_REFSCL: rd_mux = refscl_q;
      `RGTLC_OFF_AUX_LO: rd_mux = aux_lo_q;
      `RGTLC_OFF_AUX_HI: rd_mux = aux_hi_q;
      `RGTLC_OFF_LOCTL: rd_mux = loctl_q;
      default: rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Duplex pins: synchronised, low means active, high means off time
  reg [1:0] dup_a_sync_q;
  reg [1:0] dup_b_sync_q;
  wire off_a = dup_a_sync_q[1];
  wire off_b = dup_b_sync_q[1];
  wire off_any = off_a | off_b;
  wire off_both = off_a & off_b;
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dup_a_sync_q <= 2'h0;
      dup_b_sync_q <= 2'h0;
    end
    else
    begin
      dup_a_sync_q <= {dup_a_sync_q[0], CHAN_A_DUPLEX_OFF_PIN};
      dup_b_sync_q <= {dup_b_sync_q[0], CHAN_B_DUPLEX_OFF_PIN};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Autotune: started by the integer low byte write, busy for the band
  // search time; a new write restarts the search
  reg [31:0] tune_cnt_q;
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tune_cnt_q <= 32'h0;
      AUTOTUNE_START <= 1'b0;
      AUTOTUNE_BUSY <= 1'b0;
    end
    else
    begin
      AUTOTUNE_START <= int_lo_wr;
      if (int_lo_wr)
      begin
        tune_cnt_q <= AUTOTUNE_CYCLES;
        AUTOTUNE_BUSY <= 1'b1;
      end
      else if (tune_cnt_q > 32'h1)
        tune_cnt_q <= tune_cnt_q - 32'h1;
      else
      begin
        tune_cnt_q <= 32'h0;
        AUTOTUNE_BUSY <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs: power masks, gain codes and synthesizer words
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
      CHAN_A_ATTEN_CODE <= `RGTLC_ATT_MIN_GAIN;
      CHAN_B_ATTEN_CODE <= `RGTLC_ATT_MIN_GAIN;
      FIRST_LO_STAGE_OFF <= 1'b0;
      CHAN_A_LATER_LO_OFF <= 1'b0;
      CHAN_B_LATER_LO_OFF <= 1'b0;
      CHAN_A_IFAMP_OFF <= 1'b0;
      CHAN_B_IFAMP_OFF <= 1'b0;
      CHAN_A_VGA_OFF <= 1'b0;
      CHAN_B_VGA_OFF <= 1'b0;
      SYNTH_OFF <= 1'b0;
      LO_DIVIDE_RATIO <= 5'h02;
      LO_DIVIDE_VALID <= 1'b1;
      WHOLE_DIVIDE <= 16'h0000;
      PRIMARY_NUMERATOR <= 24'h000000;
      AUX_NUMERATOR <= 14'h0000;
      AUX_DENOMINATOR <= 14'h0002;
      REFERENCE_COUNT <= 7'h01;
      REFERENCE_DOUBLE <= 1'b0;
      REFERENCE_HALVE <= 1'b0;
    end
    else
    begin
      REG_RDATA <= REG_RD ? rd_mux : 8'h00;
      REG_RVALID <= REG_RD;
      CHAN_A_ATTEN_CODE <= code_a;
      CHAN_B_ATTEN_CODE <= code_b;
      FIRST_LO_STAGE_OFF <= mask_q[`RGTLC_BIT_STG1] & off_both;
      CHAN_A_LATER_LO_OFF <= mask_q[1] & off_any;
      CHAN_B_LATER_LO_OFF <= mask_q[2] & off_any;
      CHAN_A_IFAMP_OFF <= mask_q[3] & off_any;
      CHAN_B_IFAMP_OFF <= mask_q[4] & off_any;
      CHAN_A_VGA_OFF <= mask_q[5] & off_any;
      CHAN_B_VGA_OFF <= mask_q[6] & off_any;
      SYNTH_OFF <= mask_q[`RGTLC_BIT_SYNTH] & off_both;
      // Divide 16/8/4/2 and 00001 are one-hot and flagged valid; anything else is flagged invalid
      LO_DIVIDE_RATIO <= loctl_q[4:0];
      case (loctl_q[4:0])
        5'h10, 5'h08, 5'h04, 5'h02, 5'h01: LO_DIVIDE_VALID <= 1'b1;
        default: LO_DIVIDE_VALID <= 1'b0;
      endcase
      // Fraction words are handed to the divider exactly as stored
      WHOLE_DIVIDE <= {int_hi_q, int_lo_q};
      PRIMARY_NUMERATOR <= {num2_q, num1_q, num0_q};
      AUX_NUMERATOR <= {aux_hi_q[5:0], aux_lo_q};
      AUX_DENOMINATOR <= {den_hi_q[5:0], den_lo_q};
      REFERENCE_COUNT <= refcnt_q[6:0];
      REFERENCE_DOUBLE <= refscl_q[`RGTLC_BIT_DBL];
      REFERENCE_HALVE <= refscl_q[`RGTLC_BIT_HALF];
    end
  end
endmodule // rgtlc_core

//--- common/rgtlc_defs.vh
// Register offsets, field positions, reset values and timing for the receive control core
`ifndef RGTLC_DEFS_VH
`define RGTLC_DEFS_VH
`define RGTLC_OFF_GAIN_RST 16'h0021
`define RGTLC_OFF_RDBK_A 16'h003c
`define RGTLC_OFF_RDBK_B 16'h003d
`define RGTLC_OFF_MASK 16'h0102
`define RGTLC_OFF_GCFG 16'h0103
`define RGTLC_OFF_ATT_A 16'h0104
`define RGTLC_OFF_ATT_B 16'h0105
`define RGTLC_OFF_INT_LO 16'h1200
`define RGTLC_OFF_INT_HI 16'h1201
`define RGTLC_OFF_NUM0 16'h1202
`define RGTLC_OFF_NUM1 16'h1203
`define RGTLC_OFF_NUM2 16'h1204
`define RGTLC_OFF_DEN_LO 16'h1208
`define RGTLC_OFF_DEN_HI 16'h1209
`define RGTLC_OFF_REFCNT 16'h120c
`define RGTLC_OFF_REFSCL 16'h120e
`define RGTLC_OFF_AUX_LO 16'h1233
`define RGTLC_OFF_AUX_HI 16'h1234
`define RGTLC_OFF_LOCTL 16'h1414
`define RGTLC_MASK_RST 8'h7e
`define RGTLC_GCFG_RST 8'h01
`define RGTLC_ATT_RST 8'h00
`define RGTLC_INT_RST 8'h00
`define RGTLC_LOCTL_RST 8'h02
`define RGTLC_REFCNT_RST 8'h01
`define RGTLC_ATT_MIN_GAIN 6'h3f
`define RGTLC_ATT_TOP 6'h3f
`define RGTLC_MODE_REG 3'h1
`define RGTLC_MODE_UPDN 3'h3
`define RGTLC_BIT_STG1 0
`define RGTLC_BIT_SYNTH 7
`define RGTLC_BIT_DBL 3
`define RGTLC_BIT_HALF 0
`define RGTLC_BIT_RST_A 1
`define RGTLC_BIT_RST_B 0
`define RGTLC_CLK_NS 50
`define RGTLC_AUTOTUNE_US 200
`endif

//--- hdl/rgtlc_gain_link.v
// One channel of the two-wire up/down gain link with its attenuation counter
`timescale 1ns/1ns
`include "rgtlc_defs.vh"
module rgtlc_gain_link (
  input wire clk,
  input wire rst_n,
  input wire strobe_pin,
  input wire dir_pin,
  input wire updn_mode,
  input wire reg_mode,
  input wire [5:0] reg_code,
  input wire [1:0] step_sel,
  input wire block_reset,
  output reg [5:0] atten_code_q
);
  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers, then a history stage for edge detection
  reg [1:0] stb_sync_q;
  reg [1:0] dir_sync_q;
  reg stb_prev_q;
  reg rise_dir_q;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stb_sync_q <= 2'h0;
      dir_sync_q <= 2'h0;
      stb_prev_q <= 1'b0;
    end
    else
    begin
      stb_sync_q <= {stb_sync_q[0], strobe_pin};
      dir_sync_q <= {dir_sync_q[0], dir_pin};
      stb_prev_q <= stb_sync_q[1];
    end
  end
  // One pulse per synchronised edge, so no step is lost or repeated
  wire stb_rise = stb_sync_q[1] & ~stb_prev_q;
  wire stb_fall = ~stb_sync_q[1] & stb_prev_q;
  wire [6:0] step_w = 7'h01 << step_sel;
  wire [6:0] up_sum = {1'b0, atten_code_q} + step_w;
  reg [5:0] atten_code_d;
  ////////////////////////////////////////////////////////////////////////
  // Counter next value; a step is applied at the falling edge, once the
  // reset pattern can be ruled out, trading half a strobe of latency
  always @*
  begin
    atten_code_d = atten_code_q;
    if (block_reset)
      atten_code_d = `RGTLC_ATT_MIN_GAIN;
    else if (reg_mode)
      atten_code_d = reg_code;
    else if (updn_mode && stb_fall)
    begin
      if (dir_sync_q[1] != rise_dir_q)
        atten_code_d = `RGTLC_ATT_MIN_GAIN;
      else if (rise_dir_q)
        atten_code_d = up_sum[6] ? `RGTLC_ATT_TOP : up_sum[5:0];
      else if ({1'b0, atten_code_q} <= step_w)
        atten_code_d = 6'h00;
      else
        atten_code_d = atten_code_q - step_w[5:0];
    end
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_dir_q <= 1'b0;
      atten_code_q <= `RGTLC_ATT_MIN_GAIN;
    end
    else
    begin
      if (stb_rise && updn_mode)
        rise_dir_q <= dir_sync_q[1];
      atten_code_q <= atten_code_d;
    end
  end
endmodule // rgtlc_gain_link

//--- tb/rgtlc_core_chk.sv
// Port-level assertions for the receive control core
`timescale 1ns/1ns
module rgtlc_core_chk (
  input wire CORE_CLK,
  input wire RESETN,
  input wire REG_WR,
  input wire REG_RD,
  input wire [15:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  input wire REG_RVALID,
  input wire CHAN_A_DUPLEX_OFF_PIN,
  input wire CHAN_B_DUPLEX_OFF_PIN,
  input wire [5:0] CHAN_A_ATTEN_CODE,
  input wire FIRST_LO_STAGE_OFF,
  input wire CHAN_A_LATER_LO_OFF,
  input wire SYNTH_OFF,
  input wire [4:0] LO_DIVIDE_RATIO,
  input wire LO_DIVIDE_VALID,
  input wire [15:0] WHOLE_DIVIDE,
  input wire [23:0] PRIMARY_NUMERATOR,
  input wire AUTOTUNE_START,
  input wire AUTOTUNE_BUSY
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus steps; pin latency may be 2 or 3 edges, so both depths are accepted
  sequence s_wr(a);
    REG_WR && REG_ADDR == a;
  endsequence
  sequence s_rd(a);
    REG_RD && REG_ADDR == a;
  endsequence
  sequence s_both;
    ($past(CHAN_A_DUPLEX_OFF_PIN, 2) || $past(CHAN_A_DUPLEX_OFF_PIN, 3)) &&
    ($past(CHAN_B_DUPLEX_OFF_PIN, 2) || $past(CHAN_B_DUPLEX_OFF_PIN, 3));
  endsequence
  a_rd_answer: assert property (REG_RD |=> REG_RVALID) else $error("read unanswered");
  a_rd_cause: assert property (REG_RVALID |-> $past(REG_RD)) else $error("stray rvalid");
  a_rdbk_code: assert property (s_rd(16'h003c) ##1 $stable(CHAN_A_ATTEN_CODE) |->
    REG_RDATA == {2'b00, CHAN_A_ATTEN_CODE}) else $error("readback differs");
  a_tune_start: assert property (s_wr(16'h1200) |=> AUTOTUNE_START ##1 AUTOTUNE_BUSY[*5])
    else $error("autotune not started");
  a_tune_cause: assert property (AUTOTUNE_START |-> $past(REG_WR) &&
    $past(REG_ADDR) == 16'h1200) else $error("autotune without write");
  a_int_high: assert property (s_wr(16'h1201) |-> ##2
    WHOLE_DIVIDE[15:8] == $past(REG_WDATA, 2)) else $error("integer high byte");
  a_num_top: assert property (s_wr(16'h1204) |-> ##2
    PRIMARY_NUMERATOR[23:16] == $past(REG_WDATA, 2)) else $error("numerator top byte");
  a_stg1_both: assert property (FIRST_LO_STAGE_OFF |-> s_both) else $error("stage1 off");
  a_synth_both: assert property (SYNTH_OFF |-> s_both) else $error("synth off");
  a_later_either: assert property (CHAN_A_LATER_LO_OFF |-> $past(CHAN_A_DUPLEX_OFF_PIN, 2) ||
    $past(CHAN_A_DUPLEX_OFF_PIN, 3) || $past(CHAN_B_DUPLEX_OFF_PIN, 2) ||
    $past(CHAN_B_DUPLEX_OFF_PIN, 3)) else $error("later lo off");
  a_div_onehot: assert property (LO_DIVIDE_VALID == ($countones(LO_DIVIDE_RATIO) == 1))
    else $error("divide valid");
endmodule // rgtlc_core_chk

//--- tb/rgtlc_bb_model.sv
// Baseband controller model: gain strobe links and duplex pins
`timescale 1ns/1ns
module rgtlc_bb_model (
  input wire clk,
  output reg strobe_a,
  output reg dir_a,
  output reg strobe_b,
  output reg dir_b,
  output reg dup_a,
  output reg dup_b
);
  ////////////////////////////////////////////////////////////////////////////////
  // Strobes idle low between frames; channels start active
  initial
  begin
    strobe_a = 1'b0;
    strobe_b = 1'b0;
    dir_a = 1'b0;
    dir_b = 1'b1;
    dup_a = 1'b0;
    dup_b = 1'b0;
  end
  // One 500 ns frame; direction is set up a cycle before the rise so it
  // never moves together with the strobe, then moves mid-high for the fall
  task pulse(input logic ch, input logic dr, input logic df);
  begin
    @(posedge clk);
    if (ch) dir_b <= dr; else dir_a <= dr;
    @(posedge clk);
    if (ch) strobe_b <= 1'b1; else strobe_a <= 1'b1;
    repeat (2) @(posedge clk);
    if (ch) dir_b <= df; else dir_a <= df;
    repeat (2) @(posedge clk);
    if (ch) strobe_b <= 1'b0; else strobe_a <= 1'b0;
    repeat (4) @(posedge clk);
    // Released line shows the inverse, never a stale level
    if (ch) dir_b <= ~df; else dir_a <= ~df;
  end
  endtask
  // Duplex pins: high is off time
  task set_duplex(input logic a, input logic b);
  begin
    @(posedge clk);
    dup_a <= a;
    dup_b <= b;
  end
  endtask
endmodule // rgtlc_bb_model

//--- tb/testbench.sv
// Self-checking bench for the receive control core
`timescale 1ns/1ns
`include "rgtlc_defs.vh"
module testbench;
  localparam [175:0] PA = {16'h1200, 16'h1234, 16'h1233, 16'h120e, 16'h120c, 16'h1209,
    16'h1208, 16'h1204, 16'h1203, 16'h1202, 16'h1201};
  reg clk, resetn, wr_q, rd_q, d, f, ch;
  reg [15:0] addr;
  reg [7:0] wdata, m;
  reg [7:0] v [0:10];
  reg [5:0] ea, eb;
  wire sa, da, sb, db, pa, pb, rvalid, lo_ok, dbl, hlf, at_start, at_busy;
  wire [7:0] rdata, offs;
  wire [5:0] code_a, code_b;
  wire [4:0] lo_div;
  wire [15:0] whole;
  wire [23:0] num;
  wire [13:0] auxn, den;
  wire [6:0] rcnt;
  integer error_cnt, checked, i, s, k;
  ////////////////////////////////////////////////////////////////////////////////
  rgtlc_core #(.AUTOTUNE_CYCLES(10)) rgtlc_core_inst (.CORE_CLK(clk), .RESETN(resetn),
    .REG_WR(wr_q), .REG_RD(rd_q), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .CHAN_A_GAIN_STEP_STROBE_PIN(sa), .CHAN_A_GAIN_STEP_DIRECTION_PIN(da),
    .CHAN_B_GAIN_STEP_STROBE_PIN(sb), .CHAN_B_GAIN_STEP_DIRECTION_PIN(db),
    .CHAN_A_DUPLEX_OFF_PIN(pa), .CHAN_B_DUPLEX_OFF_PIN(pb), .CHAN_A_ATTEN_CODE(code_a),
    .CHAN_B_ATTEN_CODE(code_b), .FIRST_LO_STAGE_OFF(offs[0]), .CHAN_A_LATER_LO_OFF(offs[1]),
    .CHAN_B_LATER_LO_OFF(offs[2]), .CHAN_A_IFAMP_OFF(offs[3]), .CHAN_B_IFAMP_OFF(offs[4]),
    .CHAN_A_VGA_OFF(offs[5]), .CHAN_B_VGA_OFF(offs[6]), .SYNTH_OFF(offs[7]),
    .LO_DIVIDE_RATIO(lo_div), .LO_DIVIDE_VALID(lo_ok), .WHOLE_DIVIDE(whole),
    .PRIMARY_NUMERATOR(num), .AUX_NUMERATOR(auxn), .AUX_DENOMINATOR(den),
    .REFERENCE_COUNT(rcnt), .REFERENCE_DOUBLE(dbl), .REFERENCE_HALVE(hlf),
    .AUTOTUNE_START(at_start), .AUTOTUNE_BUSY(at_busy));
  rgtlc_bb_model rgtlc_bb_model_inst (.clk(clk), .strobe_a(sa), .dir_a(da), .strobe_b(sb),
    .dir_b(db), .dup_a(pa), .dup_b(pb));
  // 20 MHz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, count, report
  task chk(input [23:0] seen, input [23:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [15:0] a, input [7:0] dt);
  begin
    @(posedge clk);
    wr_q <= 1'b1;
    addr <= a;
    wdata <= dt;
    @(posedge clk);
    wr_q <= 1'b0;
  end
  endtask
  task rd(input [15:0] a, input [7:0] e);
  begin
    @(posedge clk);
    rd_q <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_q <= 1'b0;
    #1;
    chk(rvalid, 1'b1);
    chk(rdata, e);
  end
  endtask
  task settle(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  // Saturating step; differing direction levels mean link reset
  function [5:0] nxt(input [5:0] c, input r, input fl, input [1:0] st);
    if (r != fl) nxt = 6'h3f;
    else if (fl) nxt = (c + (1 << st) > 63) ? 6'h3f : c + (1 << st);
    else nxt = (c < (1 << st)) ? 6'h00 : c - (1 << st);
  endfunction
  task wrap_up;
  begin
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    error_cnt = 0;
    checked = 0;
    resetn = 1'b0;
    wr_q = 1'b0;
    rd_q = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    void'($urandom(32'h6918));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    settle(4);
    chk({code_a, code_b}, 12'h000);
    chk({offs, lo_div}, {8'h00, 5'h02});
    rd(`RGTLC_OFF_MASK, `RGTLC_MASK_RST);
    rd(`RGTLC_OFF_GCFG, 8'h01);
    rd(16'h0050, 8'h00);
    for (i = 0; i < 8; i = i + 1)
    begin
      ea = (i == 0) ? 6'd42 : $urandom % 43;
      eb = $urandom % 43;
      wr(`RGTLC_OFF_ATT_A, {2'b00, ea});
      wr(`RGTLC_OFF_ATT_B, {2'b00, eb});
      settle(2);
      chk({code_a, code_b}, {ea, eb});
      rd(`RGTLC_OFF_RDBK_A, {2'b00, ea});
      rd(`RGTLC_OFF_RDBK_B, {2'b00, eb});
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      m = (i < 4) ? 8'hff : $urandom;
      wr(`RGTLC_OFF_MASK, m);
      rgtlc_bb_model_inst.set_duplex(i[0], i[1]);
      settle(4);
      chk(offs, m & {i[0] & i[1], {6{i[0] | i[1]}}, i[0] & i[1]});
    end
    rgtlc_bb_model_inst.set_duplex(1'b0, 1'b0);
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(`RGTLC_OFF_LOCTL, (i == 4) ? 8'h03 : 8'h02 << i);
      settle(2);
      chk({lo_ok, lo_div}, (i == 4) ? 6'h03 : {1'b1, 5'h02 << i});
    end
    for (i = 0; i < 11; i = i + 1)
      v[i] = $urandom;
    v[4] = v[4] | 8'h02;
    for (i = 0; i < 11; i = i + 1)
      wr(PA[i * 16 +: 16], v[i]);
    #1;
    chk(at_start, 1'b1);
    settle(2);
    chk(at_busy, 1'b1);
    chk(whole, {v[0], v[10]});
    chk(num, {v[3], v[2], v[1]});
    chk(auxn, {v[9][5:0], v[8]});
    chk(den, {v[5][5:0], v[4]});
    chk({rcnt, dbl, hlf}, {v[6][6:0], v[7][3], v[7][0]});
    rd(16'h1209, {2'b00, v[5][5:0]});
    settle(12);
    chk(at_busy, 1'b0);
    for (s = 0; s < 4; s = s + 1)
    begin
      wr(`RGTLC_OFF_GCFG, {3'b000, s[1:0], `RGTLC_MODE_UPDN});
      wr(`RGTLC_OFF_GAIN_RST, 8'h03);
      ea = 6'h3f;
      eb = 6'h3f;
      for (k = 0; k < 14; k = k + 1)
      begin
        ch = (k < 10) ? 1'b0 : $urandom;
        d = (k < 2) ? 1'b1 : (k < 10) ? 1'b0 : $urandom;
        f = (k == 13) ? ~d : d;
        rgtlc_bb_model_inst.pulse(ch, d, f);
        if (ch) eb = nxt(eb, d, f, s[1:0]);
        else ea = nxt(ea, d, f, s[1:0]);
        settle(3);
        chk({code_a, code_b}, {ea, eb});
      end
      wr(`RGTLC_OFF_ATT_A, 8'h05);
      settle(2);
      rd(`RGTLC_OFF_RDBK_A, {2'b00, ea});
    end
    wr(`RGTLC_OFF_GCFG, 8'h01);
    wr(`RGTLC_OFF_GAIN_RST, 8'h03);
    wr(`RGTLC_OFF_ATT_A, 8'h07);
    rgtlc_bb_model_inst.pulse(1'b0, 1'b0, 1'b0);
    settle(3);
    chk(code_a, 6'h07);
    wrap_up;
  end
  // Watchdog cuts a hang short
  initial
  begin
    #1000000;
    error_cnt = error_cnt + 1;
    wrap_up;
  end
endmodule // testbench
bind rgtlc_core rgtlc_core_chk rgtlc_core_chk_inst (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .CHAN_A_DUPLEX_OFF_PIN(CHAN_A_DUPLEX_OFF_PIN), .CHAN_B_DUPLEX_OFF_PIN(CHAN_B_DUPLEX_OFF_PIN),
  .CHAN_A_ATTEN_CODE(CHAN_A_ATTEN_CODE), .FIRST_LO_STAGE_OFF(FIRST_LO_STAGE_OFF),
  .CHAN_A_LATER_LO_OFF(CHAN_A_LATER_LO_OFF), .SYNTH_OFF(SYNTH_OFF),
  .LO_DIVIDE_RATIO(LO_DIVIDE_RATIO), .LO_DIVIDE_VALID(LO_DIVIDE_VALID),
  .WHOLE_DIVIDE(WHOLE_DIVIDE), .PRIMARY_NUMERATOR(PRIMARY_NUMERATOR),
  .AUTOTUNE_START(AUTOTUNE_START), .AUTOTUNE_BUSY(AUTOTUNE_BUSY));
